/* File: common/bts_cfg.svh */
`ifndef BTS_CFG_SVH
`define BTS_CFG_SVH

// Fields of host output word 3.
`define BTS_W3_TYPE_LSB 0
`define BTS_W3_LAST 3
`define BTS_W3_TS1 4
`define BTS_W3_TS2 5
`define BTS_W3_BLK_LSB 8

// Transfer type codes.
`define BTS_T_RES 3'h1
`define BTS_T_CFG 3'h2
`define BTS_T_TPL 3'h4
`define BTS_T_STAT 3'h5
`define BTS_T_PROG 3'h7

// Block numbering and sizes.
`define BTS_NUM_CFG 8'h87
`define BTS_TPL_FIRST 8'h88
`define BTS_RES_BLOCKS 3'h4
`define BTS_PROG_BLOCK 3'h4
`define BTS_BLK_WORDS 7'h40
`define BTS_LAST_WORD 7'h3F
`define BTS_DATA_LIMIT 7'h3E
`define BTS_PROG_WORDS 7'h0A
`define BTS_PROG_BITS 8'hA0

// Flag in reply word 1 of a programmed block.
`define BTS_ERR_OVERFLOW 16'h0001

`endif

/* File: common/bts_pkg.sv */
package bts_pkg;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_LOAD  = 3'b010,
    S_PUSH  = 3'b011,
    S_SCAN  = 3'b100,
    S_WRITE = 3'b101
  } bts_state_t;

  typedef logic [15:0] bts_word_t;

endpackage

/* File: rtl/bts_buf2.sv */
`timescale 1ns/1ps
`default_nettype none

module bts_buf2 #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [$clog2(DEPTH):0] cnt;
    logic [$clog2(DEPTH)-1:0] wp;
    logic [$clog2(DEPTH)-1:0] rp;
  } bts_buf_t;

  bts_buf_t st_q, st_d;
  logic push, pop;

  assign in_ready_o = (st_q.cnt != DEPTH[$clog2(DEPTH):0]);
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o = st_q.mem[st_q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data_i;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/bts_selector.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bts_cfg.svh"

// Operation
// R1 - Results, configuration and template blocks only.
// R2 - Four results blocks, fourth is programmable.
// R3 - Programmable block served only on this port.
// R4 - 135 configuration blocks, 64 words maximum.
// R5 - Template blocks numbered from 136 upward.
// R6 - Host asks length 0, device sets length.
// R7 - Host addresses group 0, module 0.
// R8 - Only the host starts a transfer.
// R9 - Results blocks only go out on reads.
// R10 - Host sets bit 0 for results.
// R11 - Bits 4 and 5 pick the toolset.
// R12 - Host encodes results block number.
// R13 - Data-valid flags per toolset.
// R14 - Type 111 write loads block 4 program.
// R15 - Type 101 write loads statistics program.
// R16 - Host writes the program as 10 words.
// R17 - Block 4: flags word 1, data 2-63.
// R18 - Results emitted in program order.
// R19 - Host keeps selection within 62 words.
// R20 - Programs held only in volatile flops.
// R21 - Fixed point: integer high, fraction low.
// R22 - Counts 32-bit integer, measures 16.16.
// R23 - Three-bit transfer type code decoding.
// R24 - Wait for more blocks until last bit.
// R25 - Config receive: busy, no run, no valid.
// R26 - Undefined type code is rejected, no data.
module bts_selector (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Host selection bits and transfer request
  input wire logic [15:0] ctl_word_i,
  input wire logic bt_req_i,
  input wire logic bt_write_i,
  input wire logic [6:0] bt_len_i,
  output logic bt_done_o,
  output logic bt_reject_o,
  output logic [6:0] bt_len_o,
  // Block write data from the host
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_end_i,
  // Block read data to the host
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output bts_pkg::bts_word_t rd_data_o,
  // Result and configuration store
  output logic src_rd_o,
  output logic [2:0] src_kind_o,
  output logic src_ts_o,
  output logic [15:0] src_addr_o,
  input wire logic [31:0] src_data_i,
  output logic cfg_we_o,
  output logic [15:0] cfg_wdata_o,
  output logic cfg_commit_o,
  // Inspection status
  input wire logic [1:0] insp_done_i,
  input wire logic trig_i,
  output logic trig_o,
  output logic busy_o,
  output logic run_mode_o,
  output logic [1:0] dv_o
);
  import bts_pkg::*;

  typedef struct packed {
    bts_state_t state;
    logic [2:0] kind;
    logic [7:0] blk;
    logic ts;
    logic last;
    logic scan;
    logic stat;
    logic half;
    logic [6:0] wcnt;
    logic [7:0] idx;
    logic [31:0] val;
    logic [159:0] prog_r4;
    logic [159:0] prog_st;
    logic busy;
    logic [1:0] dv;
    logic done;
    logic rej;
    logic rd;
    logic we;
    logic commit;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [6:0] len;
  } bts_state_s_t;

  bts_state_s_t st_q, st_d;
  logic [2:0] w3_type;
  logic [7:0] w3_blk;
  logic [2:0] w3_res;
  logic w3_ts_any;
  logic start_ok;
  logic push_valid, push_ready;
  logic [15:0] push_data;
  logic [159:0] prog_cur;
  logic ovf;

  function automatic logic [7:0] bts_count(input logic [159:0] p);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 160; i++) begin
      c = c + {7'h00, p[i]};
    end
    return c;
  endfunction

  assign w3_type = ctl_word_i[`BTS_W3_TYPE_LSB +: 3];
  assign w3_blk = ctl_word_i[`BTS_W3_BLK_LSB +: 8];
  assign w3_res = ctl_word_i[`BTS_W3_BLK_LSB +: 3];
  assign w3_ts_any = ctl_word_i[`BTS_W3_TS1] | ctl_word_i[`BTS_W3_TS2];
  assign prog_cur = st_q.stat ? st_q.prog_st : st_q.prog_r4;
  // Each selected item takes two reply words.
  assign ovf = ({bts_count(prog_cur), 1'b0} > {2'b00, `BTS_DATA_LIMIT});

  // Legality of a request, decided from the type code, block number, direction and toolset bits.
  always_comb begin
    start_ok = 1'b0;
    case (w3_type) // [R23]
      `BTS_T_RES: start_ok = !bt_write_i && w3_ts_any && // [R9] [R11]
        (w3_res != 3'h0) && (w3_res <= `BTS_RES_BLOCKS); // [R2] [R12]
      `BTS_T_CFG: start_ok = (w3_blk < `BTS_NUM_CFG); // [R4]
      `BTS_T_TPL: start_ok = (w3_blk >= `BTS_TPL_FIRST); // [R5]
      `BTS_T_STAT: start_ok = 1'b1; // [R15]
      `BTS_T_PROG: start_ok = bt_write_i; // [R14]
      default: start_ok = 1'b0; // [R1] [R26]
    endcase
  end

  assign push_valid = (st_q.state == S_PUSH);
  assign push_data = st_q.half ? st_q.val[15:0] :
    (st_q.scan ? st_q.val[31:16] : st_q.val[15:0]);

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.rej = 1'b0;
    st_d.rd = 1'b0;
    st_d.we = 1'b0;
    st_d.commit = 1'b0;
    for (int t = 0; t < 2; t++) begin
      if (st_q.state == S_PUSH && push_ready && st_q.kind == `BTS_T_RES &&
          st_q.ts == t[0]) begin
        st_d.dv[t] = 1'b0;
      end
      // A fresh result wins over the clear by a read. [R13]
      if (insp_done_i[t] && !st_q.busy) begin
        st_d.dv[t] = 1'b1;
      end
    end
    if (st_q.busy) begin
      st_d.dv = 2'b00; // [R25]
    end
    case (st_q.state)
      S_IDLE: begin
        // The length the host asks for is ignored on reads. [R6]
        if (bt_req_i) begin // [R8]
          if (!start_ok) begin
            st_d.rej = 1'b1; // [R26]
          end else begin
            st_d.kind = w3_type;
            st_d.blk = (w3_type == `BTS_T_RES) ? {5'h00, w3_res} : w3_blk;
            st_d.ts = ctl_word_i[`BTS_W3_TS2];
            st_d.last = ctl_word_i[`BTS_W3_LAST];
            st_d.wcnt = '0;
            st_d.idx = '0;
            st_d.half = 1'b0;
            st_d.stat = (w3_type == `BTS_T_STAT);
            st_d.scan = st_d.stat ||
              (w3_type == `BTS_T_RES && w3_res == `BTS_PROG_BLOCK); // [R3]
            st_d.len = bt_write_i ? bt_len_i : `BTS_BLK_WORDS; // [R6]
            if (w3_type == `BTS_T_CFG || w3_type == `BTS_T_TPL) begin
              st_d.busy = 1'b1; // [R25]
            end
            if (bt_write_i) begin
              st_d.state = S_WRITE;
            end else if (st_d.scan) begin
              st_d.val = {8'h00, st_d.blk, 16'h0000};
              st_d.state = S_PUSH;
            end else begin
              st_d.state = S_FETCH;
            end
          end
        end
      end
      S_FETCH: begin
        st_d.rd = 1'b1;
        st_d.addr = st_q.scan ? {st_q.idx, 8'h00} :
          {st_q.blk, 1'b0, st_q.wcnt};
        st_d.state = S_LOAD;
      end
      S_LOAD: begin
        if (!st_q.rd) begin
          st_d.val = src_data_i; // [R21] [R22]
          st_d.state = S_PUSH;
        end
      end
      S_PUSH: begin
        if (push_ready) begin
          st_d.wcnt = st_q.wcnt + 7'h01;
          if (st_q.wcnt == `BTS_LAST_WORD) begin
            st_d.done = 1'b1;
            st_d.state = S_IDLE;
            if (st_q.last) begin
              st_d.busy = 1'b0; // [R24]
            end
          end else if (!st_q.scan) begin
            st_d.state = S_FETCH;
          end else if (st_q.wcnt == 7'h00) begin
            st_d.val = {ovf ? `BTS_ERR_OVERFLOW : 16'h0000, 16'h0000}; // [R17]
          end else if (st_q.wcnt == 7'h01) begin
            st_d.state = S_SCAN;
          end else if (!st_q.half && st_q.idx < `BTS_PROG_BITS) begin
            st_d.half = 1'b1;
          end else begin
            st_d.half = 1'b0;
            if (st_q.idx < `BTS_PROG_BITS) begin
              st_d.idx = st_q.idx + 8'h01;
            end
            st_d.state = S_SCAN;
          end
        end
      end
      S_SCAN: begin
        // Items go out in program bit order; the rest pads with zero.
        if (st_q.idx < `BTS_PROG_BITS &&
            st_q.wcnt <= `BTS_DATA_LIMIT) begin // [R18] [R17]
          if (prog_cur[st_q.idx]) begin
            st_d.state = S_FETCH;
          end else begin
            st_d.idx = st_q.idx + 8'h01;
          end
        end else begin
          st_d.idx = `BTS_PROG_BITS;
          st_d.half = 1'b0;
          st_d.val = '0;
          st_d.state = S_PUSH;
        end
      end
      S_WRITE: begin
        if (wr_valid_i) begin
          if (st_q.wcnt < `BTS_BLK_WORDS) begin // [R4]
            st_d.wcnt = st_q.wcnt + 7'h01;
            if (st_q.kind == `BTS_T_PROG && st_q.wcnt < `BTS_PROG_WORDS) begin
              st_d.prog_r4[st_q.wcnt[3:0]*16 +: 16] = wr_data_i; // [R14]
            end else if (st_q.kind == `BTS_T_STAT &&
                         st_q.wcnt < `BTS_PROG_WORDS) begin
              st_d.prog_st[st_q.wcnt[3:0]*16 +: 16] = wr_data_i; // [R15]
            end else if (st_q.kind == `BTS_T_CFG ||
                         st_q.kind == `BTS_T_TPL) begin
              st_d.we = 1'b1;
              st_d.addr = {st_q.blk, 1'b0, st_q.wcnt};
              st_d.wdata = wr_data_i;
            end
          end
          if (wr_end_i) begin
            st_d.done = 1'b1;
            st_d.state = S_IDLE;
            if (st_q.busy && st_q.last) begin
              st_d.busy = 1'b0; // [R24]
              st_d.commit = 1'b1;
            end
          end
        end
      end
      default: st_d.state = S_IDLE;
    endcase
  end

  // Programs live only in these flops and are lost with power. [R20]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  bts_buf2 #(
    .W(16),
    .DEPTH(2)
  ) u_rd_buf (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  assign wr_ready_o = (st_q.state == S_WRITE);
  assign bt_done_o = st_q.done;
  assign bt_reject_o = st_q.rej;
  assign bt_len_o = st_q.len;
  assign src_rd_o = st_q.rd;
  assign src_kind_o = st_q.kind;
  assign src_ts_o = st_q.ts;
  assign src_addr_o = st_q.addr;
  assign cfg_we_o = st_q.we;
  assign cfg_wdata_o = st_q.wdata;
  assign cfg_commit_o = st_q.commit;
  assign busy_o = st_q.busy;
  assign run_mode_o = !st_q.busy; // [R25]
  assign trig_o = trig_i && !st_q.busy; // [R25]
  assign dv_o = st_q.dv;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_undef_reject: assert property ( // [R26]
    st_q.state == S_IDLE && bt_req_i && (w3_type == 3'h0 ||
    w3_type == 3'h3 || w3_type == 3'h6) |=> bt_reject_o &&
    st_q.state == S_IDLE ##1 !rd_valid_o)
    else $error("undefined type not rejected");
  a_no_self_start: assert property ( // [R8]
    st_q.state == S_IDLE && !bt_req_i |=> st_q.state == S_IDLE)
    else $error("transfer started without request");
  a_res_write_rej: assert property ( // [R9]
    st_q.state == S_IDLE && bt_req_i && bt_write_i &&
    w3_type == `BTS_T_RES |=> bt_reject_o)
    else $error("results write accepted");
  a_cfg_range: assert property ( // [R4]
    st_q.state == S_IDLE && bt_req_i && w3_type == `BTS_T_CFG &&
    w3_blk >= `BTS_NUM_CFG |=> bt_reject_o)
    else $error("configuration block out of range");
  a_tpl_range: assert property ( // [R5]
    st_q.state == S_IDLE && bt_req_i && w3_type == `BTS_T_TPL &&
    w3_blk < `BTS_TPL_FIRST |=> bt_reject_o)
    else $error("template block below 136");
  a_busy_gates: assert property ( // [R25]
    busy_o |-> !trig_o && !run_mode_o ##1 (busy_o || dv_o == 2'b00))
    else $error("busy does not gate triggers");
  a_dv_set: assert property ( // [R13]
    insp_done_i[0] && !busy_o |=> dv_o[0])
    else $error("data valid not set");
  a_last_release: assert property ( // [R24]
    st_q.state == S_WRITE && wr_valid_i && wr_end_i && busy_o &&
    st_q.last |=> !busy_o && cfg_commit_o)
    else $error("last block did not release busy");
  a_prog_load: assert property ( // [R14]
    st_q.state == S_WRITE && st_q.kind == `BTS_T_PROG && wr_valid_i &&
    st_q.wcnt == 7'h00 |=> st_q.prog_r4[15:0] == $past(wr_data_i))
    else $error("program word not stored");
  a_read_len: assert property ( // [R6]
    st_q.state == S_PUSH |-> bt_len_o == `BTS_BLK_WORDS)
    else $error("read length not 64");

  c_res_read: cover property (
    st_q.state == S_PUSH && st_q.wcnt == `BTS_LAST_WORD && push_ready);
  c_prog_scan: cover property (st_q.scan && st_q.state == S_FETCH);
  c_cfg_commit: cover property (cfg_commit_o);
  c_stall: cover property (rd_valid_o && !rd_ready_i && !push_ready);

endmodule

`default_nettype wire

/* File: tb/bts_store_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the result and configuration store behind the selector.
// The answer is valid for one cycle only, then scrambled, so that a late
// capture by the selector shows up as bad data.
module bts_store_model (
  // Clock
  input wire logic clk_sys_i,
  // Fetch port
  input wire logic src_rd_i,
  input wire logic [15:0] src_addr_i,
  output logic [31:0] src_data_o
);
  always_ff @(posedge clk_sys_i) begin
    if (src_rd_i) begin
      src_data_o <= {~src_addr_i, src_addr_i ^ 16'h5A3C};
    end else begin
      src_data_o <= ~src_data_o;
    end
  end
endmodule

`default_nettype wire

/* File: tb/block_transfer_selector_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module block_transfer_selector_bench;
  import bts_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] ctl_word_i = 16'h0000;
  logic [15:0] wr_data_i = 16'h0000;
  logic bt_req_i = 1'b0, bt_write_i = 1'b0, wr_valid_i = 1'b0;
  logic wr_end_i = 1'b0, rd_ready_i = 1'b0, trig_i = 1'b0;
  logic [6:0] bt_len_i = 7'h00;
  logic [1:0] insp_done_i = 2'h0;
  logic bt_done_o, bt_reject_o, wr_ready_o, rd_valid_o, src_rd_o, src_ts_o;
  logic cfg_we_o, cfg_commit_o, trig_o, busy_o, run_mode_o;
  logic [6:0] bt_len_o;
  logic [2:0] src_kind_o;
  logic [15:0] src_addr_o, cfg_wdata_o;
  logic [31:0] src_data_i;
  logic [1:0] dv_o;
  bts_word_t rd_data_o;
  int n_fail = 0, total_checks = 0, cyc = 0;
  int n_done = 0, n_rej = 0, n_com = 0;
  bts_word_t rdq[$], cfgq[$], expq[$];
  logic [15:0] prog [10];
  logic [16:0] bad [10] = '{17'h00110, 17'h00113, 17'h00116, 17'h10111,
    17'h00011, 17'h00511, 17'h00101, 17'h08702, 17'h08704, 17'h00417};

  bts_selector uut (.clk_sys_i, .sys_rst_i, .ctl_word_i, .bt_req_i,
    .bt_write_i, .bt_len_i, .bt_done_o, .bt_reject_o, .bt_len_o,
    .wr_valid_i, .wr_ready_o, .wr_data_i, .wr_end_i, .rd_valid_o,
    .rd_ready_i, .rd_data_o, .src_rd_o, .src_kind_o, .src_ts_o,
    .src_addr_o, .src_data_i, .cfg_we_o, .cfg_wdata_o, .cfg_commit_o,
    .insp_done_i, .trig_i, .trig_o, .busy_o, .run_mode_o, .dv_o);

  bts_store_model store (.clk_sys_i, .src_rd_i(src_rd_o),
    .src_addr_i(src_addr_o), .src_data_o(src_data_i));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Outputs are collected at the falling edge, where they have settled.
  always @(negedge clk_sys_i) begin
    if (rd_valid_o === 1'b1 && rd_ready_i) rdq.push_back(rd_data_o);
    if (cfg_we_o === 1'b1) cfgq.push_back(cfg_wdata_o);
    if (bt_done_o === 1'b1) n_done++;
    if (bt_reject_o === 1'b1) n_rej++;
    if (cfg_commit_o === 1'b1) n_com++;
  end

  // The reader stalls about one cycle in four.
  always @(posedge clk_sys_i) begin
    #10 rd_ready_i = ($urandom % 4) != 0;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic req(input logic [15:0] ctl, input logic wr);
    @(posedge clk_sys_i);
    #10;
    ctl_word_i = ctl;
    bt_write_i = wr;
    bt_req_i = 1'b1;
    @(posedge clk_sys_i);
    #10;
    bt_req_i = 1'b0;
  endtask

  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && (n_done < n || rdq.size() < expq.size());
         i++) @(posedge clk_sys_i);
    #10;
  endtask

  task automatic exp_plain(input logic [7:0] blk);
    expq.delete();
    for (int k = 0; k < 64; k++) expq.push_back({blk, 1'b0, 7'(k)} ^ 16'h5A3C);
  endtask

  // Items beyond 31 (62 words) are dropped and flagged in word 1.
  task automatic exp_prog(input logic [7:0] blk);
    logic [15:0] a;
    int n;
    expq = {16'(blk), 16'h0000};
    n = 0;
    for (int i = 0; i < 160; i++) begin
      if (prog[i / 16][i % 16]) begin
        a = {8'(i), 8'h00};
        if (n < 31) expq.push_back(~a);
        if (n < 31) expq.push_back(a ^ 16'h5A3C);
        n++;
      end
    end
    if (n > 31) expq[1] = 16'h0001;
    while (expq.size() < 64) expq.push_back(16'h0000);
  endtask

  task automatic rd_blk(input logic [15:0] ctl);
    int d;
    d = n_done + 1;
    rdq.delete();
    req(ctl, 1'b0);
    wait_done(d);
    `CHK(rdq.size(), 64)
    `CHK(bt_len_o, 7'h40)
    for (int k = 0; k < 64; k++) `CHK(rdq[k], expq[k])
  endtask

  task automatic wr_blk(input logic [15:0] ctl, input int n);
    int d;
    d = n_done + 1;
    expq.delete();
    rdq.delete();
    req(ctl, 1'b1);
    for (int i = 0; i < n; i++) begin
      wr_valid_i = 1'b1;
      wr_data_i = prog[i];
      wr_end_i = (i == n - 1);
      for (int j = 0; j < 50 && wr_ready_o !== 1'b1; j++) begin
        @(posedge clk_sys_i);
        #10;
      end
      @(posedge clk_sys_i);
      #10;
    end
    wr_valid_i = 1'b0;
    wr_end_i = 1'b0;
    wait_done(d);
    `CHK(rdq.size(), 0)
  endtask

  initial begin
    logic ts;
    int r;
    void'($urandom(46));
    repeat (20) @(posedge clk_sys_i);
    #10 sys_rst_i = 1'b0;
    `CHK(busy_o, 1'b0)
    `CHK(run_mode_o, 1'b1)
    `CHK(dv_o, 2'h0)
    for (int i = 0; i < 10; i++) begin
      r = n_rej;
      req(bad[i][15:0], bad[i][16]);
      repeat (3) @(posedge clk_sys_i);
      `CHK(n_rej - r, 1)
    end
    `CHK(rdq.size(), 0)
    for (int b = 1; b < 4; b++) begin
      ts = $urandom % 2;
      exp_plain(8'(b));
      @(posedge clk_sys_i);
      #10 insp_done_i = ts ? 2'b10 : 2'b01;
      @(posedge clk_sys_i);
      #10 insp_done_i = 2'b00;
      `CHK(dv_o[ts], 1'b1)
      rd_blk({8'(b), 2'b00, ts, ~ts, 4'h1});
      `CHK(dv_o[ts], 1'b0)
      `CHK(src_ts_o, ts)
      `CHK(src_kind_o, 3'h1)
    end
    exp_plain(8'h86);
    rd_blk(16'h8602);
    for (int t = 0; t < 3; t++) begin
      foreach (prog[i]) prog[i] = 16'h0000;
      prog[0] = (t == 2) ? 16'hFFFF : 16'($urandom);
      prog[1] = (t == 2) ? 16'hFFFF : 16'h0000;
      prog[2] = (t == 2) ? 16'h00FF : 16'h0000;
      prog[3] = (t == 2) ? 16'h0000 : 16'($urandom) & 16'h00FF;
      wr_blk((t == 1) ? 16'h0005 : 16'h0007, 10);
      exp_prog((t == 1) ? 8'h02 : 8'h04);
      rd_blk((t == 1) ? 16'h0215 : 16'h0411);
    end
    for (int i = 0; i < 3; i++) prog[i] = 16'($urandom);
    cfgq.delete();
    wr_blk(16'h0502, 3);
    `CHK(busy_o, 1'b1)
    `CHK(run_mode_o, 1'b0)
    for (int i = 0; i < 3; i++) `CHK(cfgq[i], prog[i])
    trig_i = 1'b1;
    insp_done_i = 2'b01;
    @(posedge clk_sys_i);
    #10 insp_done_i = 2'b00;
    @(posedge clk_sys_i);
    #10;
    `CHK(trig_o, 1'b0)
    `CHK(dv_o, 2'h0)
    wr_blk(16'h060A, 1);
    `CHK(n_com, 1)
    `CHK(busy_o, 1'b0)
    `CHK(trig_o, 1'b1)
    insp_done_i = 2'b10;
    @(posedge clk_sys_i);
    #10 insp_done_i = 2'b00;
    @(posedge clk_sys_i);
    #10;
    `CHK(dv_o[1], 1'b1)
    exp_plain(8'h88);
    rd_blk(16'h880C);
    `CHK(busy_o, 1'b0)
    complete_run();
  end
endmodule

`default_nettype wire
